//--- dmc_pkg.sv
// Constants for the host-side controller of a 64K x 9 dynamic RAM module.
// Assumes a 20 MHz core clock; all times are converted to cycles here.
package dmc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int ROW_BITS      = 8;
  localparam int COL_BITS      = 8;
  localparam int DATA_BITS     = 8;
  localparam int NUM_ROWS      = 256;
  localparam int INIT_CYCLES   = 8;
  localparam int POWERUP_US    = 100;
  localparam int REFRESH_MS    = 4;
  localparam int RAS_PRE_NS    = 120;
  localparam int RAS_LOW_NS    = 200;
  localparam int RCD_NS        = 35;
  localparam int CAS_LOW_NS    = 135;
  localparam int CAS_PRE_NS    = 80;
  localparam int RAH_NS        = 30;

  // Least times round up, refresh interval rounds down.
  localparam int POWERUP_CYC   = (POWERUP_US * 1000 + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int REF_INT_CYC   = (REFRESH_MS * 1000000 / NUM_ROWS)
                                 / CLK_PERIOD_NS;
  localparam int RAS_PRE_CYC   = (RAS_PRE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int RAS_LOW_CYC   = (RAS_LOW_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int RCD_CYC       = (RCD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CAS_LOW_CYC   = (CAS_LOW_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int CAS_PRE_CYC   = (CAS_PRE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int RAH_CYC       = (RAH_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int TMR_BITS      = 12;

endpackage : dmc_pkg

//--- dmc_sync.sv
// Three-stage input synchroniser for pins arriving from outside core_clk.
// Assumes a free-running core clock; a change counts once stages agree.
`timescale 1ns/1ps
`default_nettype none
module dmc_sync #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  wire  [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      sync_out <= '0;
    end
    else
    begin
      s1_reg   <= pin_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      sync_out <= (agree & s3_reg) | (~agree & sync_out);
    end
  end

endmodule : dmc_sync
`default_nettype wire

//--- dmc_ctrl.sv
// Host controller driving a 64K x 9 asynchronous DRAM module by its pins.
// Assumes one 20 MHz clock; the module pins are the only link.
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl #(
  parameter int POWERUP_CYC = dmc_pkg::POWERUP_CYC,
  parameter int REF_INT_CYC = dmc_pkg::REF_INT_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // User request
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_page,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  input  wire logic        req_wparity,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata,
  output logic             rsp_rparity,
  output logic             init_done,
  // Module pins
  output logic             row_strobe_n,
  output logic             col_strobe_n,
  output logic             parity_col_strobe_n,
  output logic             write_en_n,
  output logic [7:0]       muxed_addr_lines,
  input  wire logic [7:0]  shared_data_lines_in,
  output logic [7:0]       shared_data_lines_out,
  output logic             shared_data_lines_oe,
  output logic             parity_data_in,
  input  wire logic        parity_data_out
);

  // ****************************************************************
  // State and storage
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_POWERUP, ST_INIT, ST_IDLE, ST_ROW, ST_RCD, ST_CAS,
    ST_CAS_PRE, ST_RAS_HOLD, ST_PRECHARGE
  } dmc_state_type;

  dmc_state_type         state_reg;
  logic [15:0]           pwr_reg;
  logic [11:0]           tmr_reg;
  logic [11:0]           ref_tmr_reg;
  logic                  ref_pend_reg;
  logic                  ref_cycle_reg;
  logic [7:0]            ref_row_reg;
  logic [3:0]            init_cnt_reg;
  logic [7:0]            open_row_reg;
  logic                  write_reg;
  logic [7:0]            col_reg;
  logic                  init_done_reg;
  logic [8:0]            rd_sync;

  wire       tmr_done   = (tmr_reg == 12'h000);
  wire       ref_due    = (ref_tmr_reg == 12'h000);
  wire [7:0] req_row    = req_addr[15:8];
  wire [7:0] req_col    = req_addr[7:0];
  wire       page_hit   = req_valid && req_page && !ref_pend_reg
                          && (req_row == open_row_reg);
  wire       take_req   = (state_reg == ST_IDLE) && req_valid
                          && !ref_pend_reg;
  // A page request is taken only once both column strobes are high again.
  // The edge that ends the column-low window must not acknowledge it.
  wire       take_page  = (state_reg == ST_CAS_PRE) && tmr_done
                          && col_strobe_n && page_hit;

  assign req_ready = take_req || take_page;
  assign init_done = init_done_reg;

  // Read pins pass the three-stage synchroniser; sampling happens at the
  // end of the column-low window so access time is long satisfied.
  dmc_sync #(.WIDTH(9)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({parity_data_out, shared_data_lines_in}),
    .sync_out (rd_sync)
  );

  // ****************************************************************
  // Refresh timer and pending flag
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_tmr_reg  <= 12'h000;
      ref_pend_reg <= 1'b0;
    end
    else
    begin
      ref_tmr_reg  <= ref_due ? 12'(REF_INT_CYC - 1)
                              : ref_tmr_reg - 12'h001;
      // A new tick wins over the clear made by a starting refresh.
      ref_pend_reg <= (ref_due && init_done) ||
                      (ref_pend_reg && !(state_reg == ST_IDLE));
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg             <= ST_POWERUP;
      pwr_reg               <= 16'h0000;
      tmr_reg               <= 12'h000;
      ref_cycle_reg         <= 1'b0;
      ref_row_reg           <= 8'h00;
      init_cnt_reg          <= 4'h0;
      open_row_reg          <= 8'h00;
      write_reg             <= 1'b0;
      col_reg               <= 8'h00;
      init_done_reg         <= 1'b0;
      row_strobe_n          <= 1'b1;
      col_strobe_n          <= 1'b1;
      parity_col_strobe_n   <= 1'b1;
      write_en_n            <= 1'b1;
      muxed_addr_lines      <= 8'h00;
      shared_data_lines_out <= 8'h00;
      shared_data_lines_oe  <= 1'b0;
      parity_data_in        <= 1'b0;
      rsp_valid             <= 1'b0;
      rsp_rdata             <= 8'h00;
      rsp_rparity           <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (!tmr_done)
        tmr_reg <= tmr_reg - 12'h001;
      unique case (state_reg)
        ST_POWERUP:
        begin
          pwr_reg <= pwr_reg + 16'h0001;
          if (pwr_reg == 16'(POWERUP_CYC - 1))
            state_reg <= ST_INIT;
        end
        ST_INIT:
        begin
          // Dummy cycles use the refresh path and advance the row counter.
          if (init_cnt_reg == 4'(dmc_pkg::INIT_CYCLES))
          begin
            init_done_reg <= 1'b1;
            state_reg     <= ST_IDLE;
          end
          else
          begin
            init_cnt_reg     <= init_cnt_reg + 4'h1;
            ref_cycle_reg    <= 1'b1;
            muxed_addr_lines <= ref_row_reg;
            state_reg        <= ST_ROW;
          end
        end
        ST_IDLE:
        begin
          if (ref_pend_reg)
          begin
            ref_cycle_reg    <= 1'b1;
            muxed_addr_lines <= ref_row_reg;
            state_reg        <= ST_ROW;
          end
          else if (req_valid)
          begin
            ref_cycle_reg         <= 1'b0;
            write_reg             <= req_write;
            open_row_reg          <= req_row;
            col_reg               <= req_col;
            muxed_addr_lines      <= req_row;
            write_en_n            <= !req_write;
            shared_data_lines_out <= req_wdata;
            parity_data_in        <= req_wparity;
            shared_data_lines_oe  <= req_write;
            state_reg             <= ST_ROW;
          end
        end
        ST_ROW:
        begin
          // Address was set a cycle earlier, so it is stable at the edge.
          row_strobe_n <= 1'b0;
          tmr_reg      <= 12'(dmc_pkg::RAS_LOW_CYC - 1);
          if (ref_cycle_reg)
            state_reg <= ST_RAS_HOLD;
          else
            state_reg <= ST_RCD;
        end
        ST_RCD:
        begin
          // Column goes on the pins after row hold, a cycle before the strobe.
          // The requester may move on after the take, so use the copy.
          muxed_addr_lines <= col_reg;
          state_reg        <= ST_CAS;
        end
        ST_CAS:
        begin
          col_strobe_n        <= 1'b0;
          parity_col_strobe_n <= 1'b0;
          tmr_reg             <= 12'(dmc_pkg::CAS_LOW_CYC + 3);
          state_reg           <= ST_CAS_PRE;
        end
        ST_CAS_PRE:
        begin
          if (tmr_done && col_strobe_n == 1'b0)
          begin
            // Synchroniser delay is covered by the extra low cycles.
            if (!write_reg)
            begin
              rsp_rdata   <= rd_sync[7:0];
              rsp_rparity <= rd_sync[8];
              rsp_valid   <= 1'b1;
            end
            col_strobe_n         <= 1'b1;
            parity_col_strobe_n  <= 1'b1;
            shared_data_lines_oe <= 1'b0;
            write_en_n           <= 1'b1;
            tmr_reg              <= 12'(dmc_pkg::CAS_PRE_CYC - 1);
          end
          else if (tmr_done && page_hit)
          begin
            write_reg             <= req_write;
            write_en_n            <= !req_write;
            shared_data_lines_out <= req_wdata;
            parity_data_in        <= req_wparity;
            shared_data_lines_oe  <= req_write;
            muxed_addr_lines      <= req_col;
            state_reg             <= ST_CAS;
          end
          else if (tmr_done)
            state_reg <= ST_RAS_HOLD;
        end
        ST_RAS_HOLD:
        begin
          if (tmr_done)
          begin
            row_strobe_n <= 1'b1;
            if (ref_cycle_reg)
              ref_row_reg <= ref_row_reg + 8'h01;
            tmr_reg   <= 12'(dmc_pkg::RAS_PRE_CYC - 1);
            state_reg <= ST_PRECHARGE;
          end
        end
        ST_PRECHARGE:
        begin
          if (tmr_done)
            state_reg <= init_done_reg ? ST_IDLE : ST_INIT;
        end
      endcase
    end
  end

endmodule : dmc_ctrl
`default_nettype wire

//--- dmc_ctrl_chk.sv
// Pin-level checker for the DRAM module controller.
// Assumes it is bound into dmc_ctrl and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module dmc_ctrl_chk #(
  parameter int POWERUP_CYC = 2000,
  parameter int REF_INT_CYC = 312
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // User side
  input wire logic       req_ready,
  input wire logic       init_done,
  // Module pins
  input wire logic       row_strobe_n,
  input wire logic       col_strobe_n,
  input wire logic       parity_col_strobe_n,
  input wire logic       write_en_n,
  input wire logic [7:0] muxed_addr_lines,
  input wire logic [7:0] shared_data_lines_out,
  input wire logic       shared_data_lines_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Both counters saturate, so a long run cannot wrap them.
  int up_cnt;
  int ras_cnt;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_cnt  <= 0;
      ras_cnt <= 0;
    end
    else
    begin
      up_cnt  <= (up_cnt < POWERUP_CYC) ? up_cnt + 1 : up_cnt;
      ras_cnt <= ($fell(row_strobe_n) && ras_cnt < 8) ? ras_cnt + 1 : ras_cnt;
    end
  end
  property p_pwr;
    up_cnt < POWERUP_CYC |-> row_strobe_n;
  endproperty
  a_pwr: assert property (p_pwr) else $error("row strobe early");
  property p_rdy;
    req_ready |-> init_done && ras_cnt == 8;
  endproperty
  a_rdy: assert property (p_rdy) else $error("taken before init");
  property p_dummy;
    !init_done |-> col_strobe_n && parity_col_strobe_n;
  endproperty
  a_dummy: assert property (p_dummy) else $error("column in init");
  property p_open;
    !col_strobe_n |-> !row_strobe_n;
  endproperty
  a_open: assert property (p_open) else $error("column without row");
  property p_radr;
    $fell(row_strobe_n) |-> $stable(muxed_addr_lines);
  endproperty
  a_radr: assert property (p_radr) else $error("row addr moved");
  property p_cadr;
    $fell(col_strobe_n) |-> $stable(muxed_addr_lines);
  endproperty
  a_cadr: assert property (p_cadr) else $error("col addr moved");
  property p_early;
    $fell(col_strobe_n) && !write_en_n |-> $past(write_en_n) == 1'b0;
  endproperty
  a_early: assert property (p_early) else $error("late write");
  property p_wdat;
    !col_strobe_n && !write_en_n
      |-> shared_data_lines_oe && $stable(shared_data_lines_out);
  endproperty
  a_wdat: assert property (p_wdat) else $error("write data moved");
  property p_rd;
    !col_strobe_n && write_en_n |-> !shared_data_lines_oe;
  endproperty
  a_rd: assert property (p_rd) else $error("drive during read");
  c_wr: cover property ($fell(col_strobe_n) && !write_en_n);
  c_rd: cover property ($fell(col_strobe_n) && write_en_n);
  c_pg: cover property (!row_strobe_n throughout
    ($rose(col_strobe_n) ##[1:8] $fell(col_strobe_n)));
endmodule : dmc_ctrl_chk
bind dmc_ctrl dmc_ctrl_chk #(.POWERUP_CYC(POWERUP_CYC),
  .REF_INT_CYC(REF_INT_CYC)) chk (.core_clk, .rst_n, .req_ready,
  .init_done, .row_strobe_n, .col_strobe_n, .parity_col_strobe_n,
  .write_en_n, .muxed_addr_lines, .shared_data_lines_out,
  .shared_data_lines_oe);
`default_nettype wire

//--- dmc_mem_model.sv
// Behavioural 64K x 9 dynamic RAM module seen from its pins.
// Assumes the bench resolves the shared lines from the controller's output enable.
`timescale 1ns/1ps
`default_nettype none
module dmc_mem_model #(
  parameter int  ACC_NS = 135,
  parameter real RET_NS = 4.0E6
) (
  // Strobes
  input  wire logic       row_strobe_n,
  input  wire logic       col_strobe_n,
  input  wire logic       parity_col_strobe_n,
  input  wire logic       write_en_n,
  // Address and data
  input  wire logic [7:0] muxed_addr_lines,
  input  wire logic [7:0] data_in,
  input  wire logic       parity_data_in,
  output logic      [7:0] data_out,
  output logic            data_en,
  output logic            parity_data_out
);
  logic [8:0] mem [65536];
  realtime    seen [256] = '{default: 0.0};
  logic [7:0] row;
  logic [7:0] col;
  logic [7:0] pcol;
  logic       pen = 1'b0;
  initial data_en = 1'b0;
  // Outputs are not latched; a floating line shows inverted bits.
  assign data_out = data_en ? mem[{row, col}][7:0] : ~mem[{row, col}][7:0];
  assign parity_data_out = pen ? mem[{row, pcol}][8] : ~mem[{row, pcol}][8];
  always @(negedge row_strobe_n)
  begin
    row = muxed_addr_lines;
    if ($realtime - seen[row] > RET_NS)
      for (int c = 0; c < 256; c++)
        mem[{row, 8'(c)}] = ~mem[{row, 8'(c)}];
    seen[row] = $realtime;
  end
  always @(negedge col_strobe_n)
  begin
    col = muxed_addr_lines;
    if (!write_en_n)
      mem[{row, col}][7:0] = data_in;
    else
      data_en <= #(ACC_NS) 1'b1;
  end
  always @(negedge parity_col_strobe_n)
  begin
    pcol = muxed_addr_lines;
    if (!write_en_n)
      mem[{row, pcol}][8] = parity_data_in;
    else
      pen <= #(ACC_NS) 1'b1;
  end
  always @(posedge col_strobe_n)
    data_en <= 1'b0;
  always @(posedge parity_col_strobe_n)
    pen <= 1'b0;
endmodule : dmc_mem_model
`default_nettype wire

//--- test_dmc_ctrl.sv
// Self-checking bench for the DRAM module controller.
// Assumes the behavioural module model stands on the pin side.
`timescale 1ns/1ps
`default_nettype none
module test_dmc_ctrl;
  localparam int PWR = 20;
  localparam int REF = 50;
  logic        core_clk    = 1'b0;
  logic        rst_n       = 1'b0;
  logic        req_valid   = 1'b0;
  logic        req_write   = 1'b0;
  logic        req_page    = 1'b0;
  logic [15:0] req_addr    = 16'h0000;
  logic [7:0]  req_wdata   = 8'h00;
  logic        req_wparity = 1'b0;
  logic        req_ready, rsp_valid, rsp_rparity, init_done, q_en;
  logic        row_strobe_n, col_strobe_n, parity_col_strobe_n;
  logic        write_en_n, shared_data_lines_oe, parity_data_in;
  logic        parity_data_out;
  logic [7:0]  rsp_rdata, muxed_addr_lines, shared_data_lines_out, q, dq;
  logic [8:0]  shadow [logic [15:0]];
  logic [8:0]  expq [$];
  logic [15:0] corner [4] = '{16'h0000, 16'h00FF, 16'hFF00, 16'hFFFF};
  int          fails       = 0;
  int          checked     = 0;
  assign dq = shared_data_lines_oe ? shared_data_lines_out : q;
  dmc_ctrl #(.POWERUP_CYC(PWR), .REF_INT_CYC(REF)) dut (
    .core_clk, .rst_n, .req_valid, .req_write, .req_page, .req_addr,
    .req_wdata, .req_wparity, .req_ready, .rsp_valid, .rsp_rdata,
    .rsp_rparity, .init_done, .row_strobe_n, .col_strobe_n,
    .parity_col_strobe_n, .write_en_n, .muxed_addr_lines,
    .shared_data_lines_in(dq), .shared_data_lines_out,
    .shared_data_lines_oe, .parity_data_in, .parity_data_out);
  // Retention is twice one full refresh sweep, so skipped refresh shows.
  dmc_mem_model #(.RET_NS(2.0 * 256 * REF * 50)) mdl (
    .row_strobe_n, .col_strobe_n, .parity_col_strobe_n, .write_en_n,
    .muxed_addr_lines, .data_in(dq), .parity_data_in, .data_out(q),
    .data_en(q_en), .parity_data_out);
  initial forever #25 core_clk = ~core_clk;
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk(input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (exp !== got)
    begin
      fails++;
      $display("FAIL t=%0t exp=0x%h got=0x%h", $time, exp, got);
    end
  endtask : chk
  task automatic access(input logic wr, input logic pg,
                        input logic [15:0] a, input logic [8:0] d);
    int n;
    if (req_valid !== 1'b1)
      req_valid <= 1'b1;
    req_write <= wr;
    req_page <= pg;
    req_addr <= a;
    {req_wparity, req_wdata} <= d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      fails++;
      summarize();
    end
    if (wr)
      shadow[a] = d;
    else
      expq.push_back(shadow[a]);
  endtask : access
  task automatic idle(input int cycles);
    req_valid <= 1'b0;
    repeat (cycles) @(posedge core_clk);
  endtask : idle
  always @(posedge core_clk)
  begin
    if (q_en === 1'b1)
      chk(9'h000, {8'h00, shared_data_lines_oe});
    if (rsp_valid === 1'b1)
      chk(expq.size() ? expq.pop_front() : 9'hXXX,
          {rsp_rparity, rsp_rdata});
  end
  initial
  begin
    repeat (90000) @(posedge core_clk);
    fails++;
    summarize();
  end
  initial
  begin
    logic [15:0] a;
    int          n;
    void'($urandom(75724));
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    for (n = 0; n < 400 && init_done !== 1'b1; n++)
      @(posedge core_clk);
    chk(9'h001, {8'h00, init_done});
    foreach (corner[i])
      access(1'b1, 1'b0, corner[i], 9'($urandom));
    foreach (corner[i])
      access(1'b0, 1'b0, corner[i], 9'h000);
    a = 16'($urandom);
    for (n = 0; n < 8; n++)
      access(~n[2], 1'b1, {a[15:8], 8'(n[1:0] * 85)}, 9'($urandom));
    repeat (24)
    begin
      a = 16'($urandom);
      access(1'b1, 1'($urandom), a, 9'($urandom));
      access(1'b0, 1'($urandom), a, 9'h000);
    end
    idle(40000);
    foreach (corner[i])
      access(1'b0, 1'b0, corner[i], 9'h000);
    idle(1);
    for (n = 0; n < 400 && expq.size() > 0; n++)
      @(posedge core_clk);
    chk(9'h000, 9'(expq.size()));
    summarize();
  end
endmodule : test_dmc_ctrl
`default_nettype wire
